// ### rtl/tick_counter_pkg.sv
// Purpose: Shared constants for the 16-bit tick counter block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Byte addresses are four times the register index
package tick_counter_pkg;
	localparam int ADDR_W = 6;
	localparam logic [7:0] IDX_CONFIG = 8'h05;
	localparam logic [7:0] IDX_CPU_STATUS = 8'h06;
	localparam logic [7:0] IDX_IRQ = 8'h07;
	localparam logic [7:0] IDX_COUNT_LOW = 8'h0b;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h0c;
	localparam int BIT_EDGE = 6;
	localparam int BIT_SOURCE = 5;
	localparam int PS_LSB = 1;
	localparam int PS_W = 4;
	localparam int BIT_OVF_FLAG = 5;
	localparam int BIT_OVF_EN = 1;
	localparam int BIT_GLOBAL_DIS = 4;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] CONFIG_MASK = 8'h7e;
	localparam logic [7:0] IRQ_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK = 8'h22;
	localparam logic [7:0] CPU_STATUS_RESET = 8'h10;
	localparam logic [7:0] CPU_STATUS_MASK = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLOCK_HZ = 10_000_000;
	localparam int PHASES_PER_CYCLE = 4;
	localparam int PS_STAGES = 8;
endpackage

// ### rtl/tick_prescaler.sv
// Purpose: 8-bit ripple-free prescaler producing a divided level output
// Assumes: Counts one step per input edge event
// Notes: Division ratio is two to the power of the select code, capped at 256
`timescale 1ns/10ps
module tick_prescaler
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic step,
	input wire logic clear,
	input wire logic [tick_counter_pkg::PS_W-1:0] ratio_sel,
	input wire logic raw_level,
	output logic ps_out
);
	logic [tick_counter_pkg::PS_STAGES-1:0] count_ff;
	logic [tick_counter_pkg::PS_STAGES-1:0] nxt_count;
	wire top_sel = ratio_sel[tick_counter_pkg::PS_W-1];
	wire [2:0] tap = ratio_sel[2:0];

	assign nxt_count = clear ? '0 : (step ? count_ff + 8'h01 : count_ff); // see [R7]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_ff <= '0;
		else
			count_ff <= nxt_count;
	end

	// Ratio 1 passes the level; ratio 2^n takes count bit n-1
	always_comb
	begin
		if (top_sel)
			ps_out = count_ff[tick_counter_pkg::PS_STAGES-1]; // see [R12]
		else if (tap == 3'h0)
			ps_out = raw_level;
		else
			ps_out = count_ff[tap - 3'h1]; // see [R8]
	end
endmodule

// ### rtl/tick_counter.sv
// Purpose: 16-bit timer/counter with 8-bit prescaler behind an AXI4-Lite slave
// Assumes: aclk is the instruction-rate clock; external pin is asynchronous
// Notes: Overview of operation is listed below
//
// Overview of operation
// [R1] External path is synchronised after the prescaler, sampled twice per cycle; here two flops sample it once per aclk.
// [R2] Counter advances three to seven oscillator periods after the external edge.
// [R3] Count is two byte registers; one byte accessed per transfer.
// [R4] Software reads both bytes, re-reads if low byte decreased.
// [R5] A byte write blocks that byte's increment in the next cycle.
// [R6] Software writes low byte then high byte with interrupts disabled.
// [R7] Any count byte write clears the prescaler.
// [R8] Prescaler is eight bits; ratio may change while running.
// [R9] Software should clear the prescaler before changing its ratio.
// [R10] Source select set counts internal clock, clear counts pin.
// [R11] Edge select set counts rising pin edges, clear falling.
// [R12] Four-bit field selects ratio 1 to 256; top bit means 256.
// [R13] Wrap from all ones sets overflow flag; enable masks; vector clears.
// [R14] High byte increments on the cycle the low byte wraps.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tick_counter
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tick_counter_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tick_counter_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic external_count_pin,
	input wire logic vector_taken,
	output logic overflow_irq_ff
);
	logic [7:0] counter_config_reg_ff;
	logic [7:0] irq_status_enable_reg_ff;
	logic [7:0] cpu_status_reg_ff;
	logic [7:0] count_low_byte_ff;
	logic [7:0] count_high_byte_ff;
	logic pin_meta_ff;
	logic pin_sync_ff;
	logic ps_sample_a_ff;
	logic ps_sample_b_ff;
	logic ps_prev_ff;
	logic pin_prev_ff;
	logic low_hold_ff;
	logic high_hold_ff;
	logic awready_ff;
	logic wready_ff;
	logic [tick_counter_pkg::ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic ps_out;

	function automatic logic [7:0] word_index(input logic [tick_counter_pkg::ADDR_W-1:0] a);
		word_index = {4'h0, a[tick_counter_pkg::ADDR_W-1:2]};
	endfunction

	function automatic logic known_index(input logic [7:0] idx);
		known_index = (idx == tick_counter_pkg::IDX_CONFIG) ||
			(idx == tick_counter_pkg::IDX_CPU_STATUS) ||
			(idx == tick_counter_pkg::IDX_IRQ) ||
			(idx == tick_counter_pkg::IDX_COUNT_LOW) ||
			(idx == tick_counter_pkg::IDX_COUNT_HIGH);
	endfunction

	// Configuration fields
	wire src_internal = counter_config_reg_ff[tick_counter_pkg::BIT_SOURCE];
	wire edge_rising = counter_config_reg_ff[tick_counter_pkg::BIT_EDGE];
	wire [tick_counter_pkg::PS_W-1:0] ps_sel =
		counter_config_reg_ff[tick_counter_pkg::PS_LSB +: tick_counter_pkg::PS_W];

	// Pin edge detection feeds the prescaler with one step per selected edge
	wire pin_edge = edge_rising ? (pin_sync_ff & ~pin_prev_ff)
		: (~pin_sync_ff & pin_prev_ff); // see [R11]
	wire ps_step = src_internal ? 1'b1 : pin_edge; // see [R10]
	wire ps_level_in = edge_rising ? pin_sync_ff : ~pin_sync_ff;

	// Write transaction
	wire wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
	wire [7:0] wr_idx = word_index(awaddr_ff);
	wire wr_lane0 = wr_fire & wstrb_ff[0];
	wire wr_low = wr_lane0 & (wr_idx == tick_counter_pkg::IDX_COUNT_LOW); // see [R3]
	wire wr_high = wr_lane0 & (wr_idx == tick_counter_pkg::IDX_COUNT_HIGH);
	wire wr_config = wr_lane0 & (wr_idx == tick_counter_pkg::IDX_CONFIG);
	wire wr_irq = wr_lane0 & (wr_idx == tick_counter_pkg::IDX_IRQ);
	wire wr_cpu = wr_lane0 & (wr_idx == tick_counter_pkg::IDX_CPU_STATUS);
	wire [7:0] wr_byte = wdata_ff[7:0];
	wire ps_clear = wr_low | wr_high; // see [R7]

	// Prescaler output sampled through two flops on rising aclk edges; rising edge of the sampled level counts
	wire count_tick = ps_sample_b_ff & ~ps_prev_ff; // see [R1]
	wire tick_int = src_internal & (ps_sel == 4'h0);
	wire do_tick = tick_int | (~tick_int & count_tick);
	wire low_inc = do_tick & ~low_hold_ff & ~wr_low; // see [R5]
	wire low_wrap = low_inc & (&count_low_byte_ff);
	wire high_inc = low_wrap & ~high_hold_ff & ~wr_high; // see [R14]
	wire full_wrap = high_inc & (&count_high_byte_ff); // see [R13]

	// Read mux
	wire [7:0] rd_idx = word_index(s_axi_araddr);
	wire rd_ok = known_index(rd_idx);
	wire [7:0] rd_byte =
		(rd_idx == tick_counter_pkg::IDX_CONFIG) ? counter_config_reg_ff :
		(rd_idx == tick_counter_pkg::IDX_CPU_STATUS) ? cpu_status_reg_ff :
		(rd_idx == tick_counter_pkg::IDX_IRQ) ? irq_status_enable_reg_ff :
		(rd_idx == tick_counter_pkg::IDX_COUNT_LOW) ? count_low_byte_ff :
		(rd_idx == tick_counter_pkg::IDX_COUNT_HIGH) ? count_high_byte_ff : 8'h00;

	wire ovf_flag = irq_status_enable_reg_ff[tick_counter_pkg::BIT_OVF_FLAG];
	wire ovf_en = irq_status_enable_reg_ff[tick_counter_pkg::BIT_OVF_EN];
	wire glob_dis = cpu_status_reg_ff[tick_counter_pkg::BIT_GLOBAL_DIS];
	// Set wins over software write and over vector clear
	wire nxt_flag = full_wrap | (wr_irq ? wr_byte[tick_counter_pkg::BIT_OVF_FLAG]
		: (ovf_flag & ~vector_taken)); // see [R13]
	wire [7:0] irq_base = wr_irq ? (wr_byte & tick_counter_pkg::IRQ_MASK)
		: irq_status_enable_reg_ff;
	logic [7:0] nxt_irq;

	// Overflow flag bit replaced in the otherwise written or held value
	always_comb
	begin
		nxt_irq = irq_base;
		nxt_irq[tick_counter_pkg::BIT_OVF_FLAG] = nxt_flag;
	end

	tick_prescaler u_prescaler
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.step(ps_step),
		.clear(ps_clear),
		.ratio_sel(ps_sel),
		.raw_level(src_internal ? 1'b0 : ps_level_in),
		.ps_out(ps_out)
	);

	// Pin synchroniser and prescaler output sampling
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
			pin_prev_ff <= 1'b0;
			// Start high so leaving reset never reads as a rising edge
			ps_sample_a_ff <= 1'b1;
			ps_sample_b_ff <= 1'b1;
			ps_prev_ff <= 1'b1;
		end
		else
		begin
			pin_meta_ff <= external_count_pin;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
			ps_sample_a_ff <= ps_out; // see [R2]
			ps_sample_b_ff <= ps_sample_a_ff;
			ps_prev_ff <= ps_sample_b_ff;
		end
	end

	// Counter bytes and write holds
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_low_byte_ff <= 8'h00;
			count_high_byte_ff <= 8'h00;
			low_hold_ff <= 1'b0;
			high_hold_ff <= 1'b0;
		end
		else
		begin
			low_hold_ff <= wr_low; // see [R5]
			high_hold_ff <= wr_high;
			if (wr_low)
				count_low_byte_ff <= wr_byte;
			else if (low_inc)
				count_low_byte_ff <= count_low_byte_ff + 8'h01;
			if (wr_high)
				count_high_byte_ff <= wr_byte;
			else if (high_inc)
				count_high_byte_ff <= count_high_byte_ff + 8'h01; // see [R14]
		end
	end

	// Control and status registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			counter_config_reg_ff <= tick_counter_pkg::CONFIG_RESET;
			irq_status_enable_reg_ff <= tick_counter_pkg::IRQ_RESET;
			cpu_status_reg_ff <= tick_counter_pkg::CPU_STATUS_RESET;
			overflow_irq_ff <= 1'b0;
		end
		else
		begin
			if (wr_config)
				counter_config_reg_ff <= wr_byte & tick_counter_pkg::CONFIG_MASK; // see [R8]
			if (wr_cpu)
				cpu_status_reg_ff <= wr_byte & tick_counter_pkg::CPU_STATUS_MASK;
			irq_status_enable_reg_ff <= nxt_irq;
			overflow_irq_ff <= ovf_flag & ovf_en & ~glob_dis; // see [R13]
		end
	end

	// AXI4-Lite write channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= tick_counter_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_ff)
			begin
				awaddr_ff <= s_axi_awaddr;
				aw_have_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (s_axi_wvalid && wready_ff)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_have_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= known_index(wr_idx) ? tick_counter_pkg::RESP_OKAY
					: tick_counter_pkg::RESP_SLVERR;
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
			end
			if (bvalid_ff && s_axi_bready)
			begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= tick_counter_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte}; // see [R3]
			rresp_ff <= rd_ok ? tick_counter_pkg::RESP_OKAY : tick_counter_pkg::RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule

// ### test/tick_counter_checker.sv
// Purpose: Port checks for the tick counter
// Assumes: One clock domain
// Notes: Bound into every tick_counter
`timescale 1ns/10ps
module tick_counter_checker
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tick_counter_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic overflow_irq_ff
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == 4'h0;
	endsequence
	a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write accepted while pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while pending");
	a_unmapped_read: assert property (ar_unmapped |=> s_axi_rresp == tick_counter_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data above one byte");
	a_irq_quiet: assert property ($rose(aresetn) |-> !overflow_irq_ff)
		else $error("irq set out of reset");
endmodule
bind tick_counter tick_counter_checker chk
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.overflow_irq_ff(overflow_irq_ff)
);

// ### test/pin_source.sv
// Purpose: Pulse source on the external count pin
// Assumes: Pin rests low between bursts
// Notes: Pulses are slow enough for the sync delay
`timescale 1ns/10ps
module pin_source
(
	input wire logic aclk,
	output logic pin
);
	initial pin = 1'h0;
	task automatic burst(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge aclk);
			pin <= 1'h1;
			repeat (4) @(posedge aclk);
			pin <= 1'h0;
		end
	endtask
endmodule

// ### test/tb_tick_counter.sv
// Purpose: Self-checking bench for the tick counter
// Assumes: Registers one byte per word
// Notes: Pin source drives the count pin
`timescale 1ns/10ps
module tb_tick_counter;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, vec;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, r;
	int bad_count = 0;
	int samples_checked = 0;
	pin_source ps (.aclk(aclk), .pin(pin));
	tick_counter dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_count_pin(pin), .vector_taken(vec), .overflow_irq_ff(irq)
	);
	initial
	begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		repeat (50)
		begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb)
			begin
				bready <= 1'h0;
				return;
			end
		end
		bad_count++;
	endtask
	task automatic rd(input logic [5:0] a);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		repeat (50)
		begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
			if (tr)
			begin
				rready <= 1'h0;
				return;
			end
		end
		bad_count++;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		rd(a);
		chk(v, {24'h0, e});
	endtask
	// Two-byte read: re-read both halves if the low byte rolled meanwhile
	task automatic rd16(output logic [15:0] val);
		logic [7:0] lo;
		rd(6'h2c);
		lo = v[7:0];
		rd(6'h30);
		val = {v[7:0], lo};
		rd(6'h2c);
		if (v[7:0] < lo)
		begin
			rd(6'h2c);
			lo = v[7:0];
			rd(6'h30);
			val = {v[7:0], lo};
		end
	endtask
	task automatic test_reset;
		rdchk(6'h14, 8'h00);
		rdchk(6'h18, 8'h10);
		rdchk(6'h1c, 8'h00);
	endtask
	task automatic test_unmapped;
		wr(6'h00, 8'h5a);
		chk({30'h0, r}, {30'h0, tick_counter_pkg::RESP_SLVERR});
		rdchk(6'h00, 8'h00);
		chk({30'h0, r}, {30'h0, tick_counter_pkg::RESP_SLVERR});
	endtask
	task automatic test_overflow;
		int n;
		wr(6'h14, 8'h20);
		wr(6'h1c, 8'h02);
		wr(6'h18, 8'h00);
		wr(6'h2c, 8'hf0);
		wr(6'h30, 8'hff);
		n = 0;
		while (irq !== 1'h1 && n < 300)
		begin
			@(negedge aclk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
		rdchk(6'h30, 8'h00);
		rdchk(6'h1c, 8'h22);
		@(posedge aclk);
		vec <= 1'h1;
		@(posedge aclk);
		vec <= 1'h0;
		rdchk(6'h1c, 8'h02);
		chk({31'h0, irq}, 32'h0);
	endtask
	// Runs on from the internal 1:1 setting left by the overflow scenario
	task automatic test_wide;
		logic [15:0] val;
		wr(6'h2c, 8'h40);
		rdchk(6'h2c, 8'h41);
		wr(6'h2c, 8'h00);
		wr(6'h14, 8'h30);
		wr(6'h2c, 8'hff);
		wr(6'h30, 8'h12);
		rd16(val);
		chk({16'h0, val}, 32'h0000_12ff);
		repeat (200) @(posedge aclk);
		rd16(val);
		chk({16'h0, val}, 32'h0000_1300);
	endtask
	task automatic test_pin;
		logic [7:0] cfg [4] = '{8'h40, 8'h00, 8'h44, 8'h50};
		logic [7:0] ex [4] = '{8'h05, 8'h05, 8'h02, 8'h00};
		int np [4] = '{5, 5, 8, 8};
		for (int i = 0; i < 4; i++)
		begin
			wr(6'h2c, 8'h00);
			wr(6'h14, cfg[i]);
			repeat (10) @(posedge aclk);
			wr(6'h2c, 8'h00);
			ps.burst(np[i]);
			repeat (10) @(posedge aclk);
			rdchk(6'h2c, ex[i]);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		end_sim;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, vec} = 7'h0;
		{awaddr, araddr, wdata} = 44'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		test_reset;
		test_unmapped;
		test_overflow;
		test_wide;
		test_pin;
		end_sim;
	end
endmodule
